/* File: logic/dspwm_top.sv */
// dspwm_top: two-channel sub-cycle pwm with axi4-lite registers
// assumes one 50 MHz clock, synchronous active-low reset, pad logic outside
// Operation
// - two channels, own duty register and pin
// - system clock, 256-clock period, duty/256
// - mode bit: zero two, one four sub-cycles
// - bits 6 and 5 route channels to pins
// - four mode: 64-clock sub-cycles, coarse 7:2
// - four mode: extra clock when index below fine
// - two mode: 128-clock sub-cycles, coarse 7:1
// - two mode: extra clock when index below fine
// - hardware splits sub-cycles, software sets values
// - port bit one passes wave, zero low
// - direction one leaves pin an input
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
module dspwm_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  alt_out,
  input  wire logic [1:0]  alt_oe,
  input  wire logic [1:0]  pin_in,
  output logic [1:0]       pin_out,
  output logic [1:0]       pin_oe,
  output logic [1:0]       pin_in_sync
);
  logic [7:0] ctrl_q;
  logic [7:0] duty_q [dspwm_pkg::NUM_CH];
  logic [5:0] port_q;
  logic [7:0] cnt_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       aw_have_q;
  logic       w_have_q;
  logic       wr_fire;
  logic       wr_ok;
  logic       rd_ok;
  logic [7:0] rd_byte;
  logic [1:0] wave;
  logic [1:0] pin_sel;
  logic [1:0] port_data;
  logic [1:0] port_dir;
  logic       period_start;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;

  // free-running period counter; wraps every 256 clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 8'h00;
    else if (ce) cnt_q <= cnt_q + 8'h01;
  end
  assign period_start = (cnt_q == 8'hFF);

  // one channel per duty register, shared mode bit
  genvar g;
  generate
    for (g = 0; g < dspwm_pkg::NUM_CH; g++) begin : g_ch
      dspwm_chan u_chan (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ce           (ce),
        .period_start (period_start),
        .cnt          (cnt_q),
        .duty_wr      (duty_q[g]),
        .mode_wr      (ctrl_q[dspwm_pkg::MODE_BIT]),
        .wave         (wave[g])
      );
    end
  endgenerate

  // pin muxing: data bit gates the wave, direction one leaves an input
  assign pin_sel   = {ctrl_q[dspwm_pkg::CH1_SEL_BIT],
                      ctrl_q[dspwm_pkg::CH0_SEL_BIT]};
  assign port_data = port_q[dspwm_pkg::PORT_DATA_LSB +: 2];
  assign port_dir  = port_q[dspwm_pkg::PORT_DIR_LSB +: 2];
  assign pin_out   = (pin_sel & wave & port_data)
                   | (~pin_sel & alt_out);
  assign pin_oe    = (pin_sel & ~port_dir) | (~pin_sel & alt_oe);

  // pin input synchroniser, three stages; change taken when 2 and 3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q     <= 2'b00;
      sync2_q     <= 2'b00;
      sync3_q     <= 2'b00;
      pin_in_sync <= 2'b00;
    end else if (ce) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_in_sync <= (sync2_q & sync3_q) | (pin_in_sync & (sync2_q | sync3_q));
    end
  end

  // write channel: address and data captured independently, any order
  // readies drop with ce so a frozen block never claims a transfer
  assign s_axi_awready = ce && !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = ce && !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ok   = (awaddr_q == dspwm_pkg::CTRL_ADDR)
                || (awaddr_q == dspwm_pkg::DUTY0_ADDR)
                || (awaddr_q == dspwm_pkg::DUTY1_ADDR)
                || (awaddr_q == dspwm_pkg::PORT_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 4'h0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dspwm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? dspwm_pkg::RESP_OKAY
                              : dspwm_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= dspwm_pkg::CTRL_RESET;
      duty_q[0] <= dspwm_pkg::DUTY_RESET;
      duty_q[1] <= dspwm_pkg::DUTY_RESET;
      port_q    <= dspwm_pkg::PORT_RESET;
    end else if (ce && wr_fire && wstrb_q[0]) begin
      case (awaddr_q)
        dspwm_pkg::CTRL_ADDR:  ctrl_q    <= wdata_q[7:0];
        dspwm_pkg::DUTY0_ADDR: duty_q[0] <= wdata_q[7:0];
        dspwm_pkg::DUTY1_ADDR: duty_q[1] <= wdata_q[7:0];
        dspwm_pkg::PORT_ADDR:  port_q    <= wdata_q[5:0];
        default: ;
      endcase
    end
  end

  // read decode; port register also shows live channel waves in bits 9:8
  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr)
      dspwm_pkg::CTRL_ADDR:  rd_byte = ctrl_q;
      dspwm_pkg::DUTY0_ADDR: rd_byte = duty_q[0];
      dspwm_pkg::DUTY1_ADDR: rd_byte = duty_q[1];
      dspwm_pkg::PORT_ADDR:  rd_byte = {2'b00, port_q};
      default:               rd_ok   = 1'b0;
    endcase
  end

  assign s_axi_arready = ce && !s_axi_rvalid;

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dspwm_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {22'h00_0000, (s_axi_araddr == dspwm_pkg::PORT_ADDR)
                         ? wave : 2'b00, rd_byte};
        s_axi_rresp  <= rd_ok ? dspwm_pkg::RESP_OKAY
                              : dspwm_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pin driven low when selected, output, and data bit clear
  pin_low_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pin_sel[0] && !port_dir[0] && !port_data[0]) |-> !pin_out[0])
    else $error("pin0 not forced low");

  // selected input pin is not driven
  pin_input_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pin_sel[1] && port_dir[1]) |-> !pin_oe[1])
    else $error("pin1 driven while input");

  // counter advances by one per enabled clock
  cnt_step_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ce ##1 aresetn |-> cnt_q == $past(cnt_q) + 8'h01)
    else $error("period counter did not step");

  // zero duty keeps the wave low after the period starts
  zero_duty_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && period_start && duty_q[0] == 8'h00) ##1 ce [*8] |-> !wave[0])
    else $error("wave high with zero duty");

  // full-scale two-mode: wave high at sub-cycle start
  start_high_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && period_start && duty_q[0] == 8'hFF
     && !ctrl_q[dspwm_pkg::MODE_BIT]) ##1 ce ##1 ce |-> wave[0])
    else $error("wave low at full duty");

  // duty one in four-mode: only the first clock of sub-cycle 0 is high
  one_high_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && period_start && duty_q[0] == 8'h01
     && ctrl_q[dspwm_pkg::MODE_BIT]) ##1 ce ##1 ce |-> wave[0])
    else $error("fine clock missing in first sub-cycle");

  one_low_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && period_start && duty_q[0] == 8'h01
     && ctrl_q[dspwm_pkg::MODE_BIT]) ##1 ce [*3] |-> !wave[0])
    else $error("wave high past the fine clock");

  // counter wraps to zero right after the period boundary
  period_wrap_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && period_start) |=> cnt_q == 8'h00)
    else $error("period counter did not wrap");

  // clock enable low freezes counter and waves
  ce_freeze_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !ce |=> ($stable(cnt_q) && $stable(wave)))
    else $error("state moved with clock enable low");

  // bvalid follows a completed write pair by one cycle
  wr_resp_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && wr_fire) |=> s_axi_bvalid)
    else $error("write response missing");

  // no write half is taken while a response waits
  wr_busy_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
    else $error("write half taken during response");

  // read answer one cycle after the address is taken
  rd_resp_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("read response missing");

  // no new read address while an answer waits
  rd_busy_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");

  // read data stable while waiting on rready
  rd_hold_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> $stable(s_axi_rdata))
    else $error("read data changed while stalled");

  // data bit one passes the channel wave to its pin
  pass0_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pin_sel[0] && port_data[0]) |-> pin_out[0] == wave[0])
    else $error("pin0 does not carry the wave");

  pass1_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pin_sel[1] && port_data[1]) |-> pin_out[1] == wave[1])
    else $error("pin1 does not carry the wave");

  // selected output pin is driven
  pin_drive_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (pin_sel[1] && !port_dir[1]) |-> pin_oe[1])
    else $error("pin1 not driven as output");

  // filtered input follows once stages two and three agree
  sync_agree_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (ce && sync2_q == sync3_q) |=> pin_in_sync == $past(sync2_q))
    else $error("filtered input did not follow");

  // unselected pins follow the other shared function
  alt_pass_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !pin_sel[0] |-> (pin_out[0] == alt_out[0] && pin_oe[0] == alt_oe[0]))
    else $error("alt function not passed on pin0");

  alt_pass1_a: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !pin_sel[1] |-> (pin_out[1] == alt_out[1] && pin_oe[1] == alt_oe[1]))
    else $error("alt function not passed on pin1");
endmodule : dspwm_top

/* File: logic/dspwm_pkg.sv */
// dspwm_pkg: register map, field positions and sizes for the dual pwm
// assumes a 32-bit axi4-lite register bus, one aligned word per register
package dspwm_pkg;
  localparam int          DUTY_W        = 8;
  localparam int          NUM_CH        = 2;
  localparam int          ADDR_W        = 4;
  // register byte addresses
  localparam logic [3:0]  CTRL_ADDR     = 4'h0;
  localparam logic [3:0]  DUTY0_ADDR    = 4'h4;
  localparam logic [3:0]  DUTY1_ADDR    = 4'h8;
  localparam logic [3:0]  PORT_ADDR     = 4'hC;
  // control register fields
  localparam int          MODE_BIT      = 7;
  localparam int          CH1_SEL_BIT   = 6;
  localparam int          CH0_SEL_BIT   = 5;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  DUTY_RESET    = 8'h00;
  // port register fields: output bits in [1:0], direction bits in [5:4]
  localparam int          PORT_DATA_LSB = 0;
  localparam int          PORT_DIR_LSB  = 4;
  localparam logic [5:0]  PORT_RESET    = 6'h30;
  // period and sub-cycle sizes
  localparam int          PERIOD_CLKS   = 256;
  localparam int          SUB4_CLKS     = 64;
  localparam int          SUB2_CLKS     = 128;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage : dspwm_pkg

/* File: logic/dspwm_chan.sv */
// dspwm_chan: one modulator channel producing the sub-cycle waveform
// assumes a shared period counter and a period-start strobe from the top
module dspwm_chan (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       period_start,
  input  wire logic [7:0] cnt,
  input  wire logic [7:0] duty_wr,
  input  wire logic       mode_wr,
  output logic            wave
);
  logic [7:0] duty_q;
  logic       mode_q;
  logic [6:0] coarse;
  logic [1:0] fine;
  logic [1:0] sub_idx;
  logic [6:0] pos;
  logic [7:0] high_len;
  logic       wave_d;

  // shadow copy taken only at a period boundary, so no torn period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_q <= dspwm_pkg::DUTY_RESET;
      mode_q <= 1'b0;
    end else if (ce && period_start) begin
      duty_q <= duty_wr;
      mode_q <= mode_wr;
    end
  end

  // mode 1: 64-clock sub-cycles, coarse=duty[7:2], fine=duty[1:0]
  // mode 0: 128-clock sub-cycles, coarse=duty[7:1], fine=duty[0]
  assign coarse  = mode_q ? {1'b0, duty_q[7:2]} : duty_q[7:1];
  assign fine    = mode_q ? duty_q[1:0] : {1'b0, duty_q[0]};
  assign sub_idx = mode_q ? cnt[7:6] : {1'b0, cnt[7]};
  assign pos     = mode_q ? {1'b0, cnt[5:0]} : cnt[6:0];
  // extra clock in the first sub-cycles below the fine value
  assign high_len = {1'b0, coarse} + ((sub_idx < fine) ? 8'h01 : 8'h00);
  assign wave_d   = ({1'b0, pos} < high_len);

  // registered output keeps the pin glitch free
  always_ff @(posedge aclk) begin
    if (!aresetn) wave <= 1'b0;
    else if (ce) wave <= wave_d;
  end
endmodule : dspwm_chan

/* File: tb/dspwm_load.sv */
// dspwm_load: load on the two pwm pins, with pull-high and a driver
// assumes the bench drives ext_oe/ext_val to play an outside source
module dspwm_load (
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  input  wire logic [1:0] ext_oe,
  input  wire logic [1:0] ext_val,
  output logic [1:0]      pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // released pin floats up through the pull-high
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (pin_oe[i]) pin_lvl[i] = pin_out[i];
      else if (ext_oe[i]) pin_lvl[i] = ext_val[i];
      else pin_lvl[i] = 1'b1;
    end
  end
endmodule : dspwm_load

/* File: tb/dspwm_top_tb.sv */
// dspwm_top_tb: random and corner duty tests over axi4-lite
// assumes period phase unknown, so waves are matched at any rotation
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module dspwm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [3:0] awaddr = 0, wstrb = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, alt_out = 0, alt_oe = 0, ext_oe = 0;
  logic [1:0] ext_val = 0, pin_lvl, pin_out, pin_oe, pin_sync, r;
  logic [1:0] smp [512];
  logic [7:0] duty [2];
  logic [7:0] corner [6] = '{8'h00, 8'h01, 8'h03, 8'h81, 8'hFE, 8'hFF};
  logic [31:0] rd;
  int fail_count = 0, total_checks = 0, seed = 32'h081d3de4;
  always #10 aclk = ~aclk;
  dspwm_top u_dspwm_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .alt_out(alt_out), .alt_oe(alt_oe),
    .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in_sync(pin_sync));
  dspwm_load u_dspwm_load (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_oe(ext_oe), .ext_val(ext_val), .pin_lvl(pin_lvl));
  // each task opens on a fresh edge so strobes never switch twice at once
  // only the watchdog ends a wait for the answer
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rd = rdata; r = rresp;
    rready <= 0;
  endtask : axi_rd
  // level of one clock at position p of the 256-clock period
  function automatic logic exp_wave(logic [7:0] d, logic m, int p);
    int off, sub, crs, fin;
    off = m ? p % 64 : p % 128;
    sub = m ? p / 64 : p / 128;
    crs = m ? int'(d[7:2]) : int'(d[7:1]);
    fin = m ? int'(d[1:0]) : int'(d[0]);
    return off < crs + int'(sub < fin);
  endfunction : exp_wave
  // look for the expected period anywhere in 512 captured clocks
  task automatic check_waves(input logic m);
    logic ok, hit;
    for (int i = 0; i < 512; i++) begin
      @(posedge aclk);
      smp[i] = pin_out;
    end
    for (int c = 0; c < 2; c++) begin
      hit = 0;
      for (int s = 0; s < 256 && !hit; s++) begin
        ok = 1;
        for (int p = 0; p < 256; p++)
          if (smp[s+p][c] !== exp_wave(duty[c], m, p)) ok = 0;
        hit = ok;
      end
      `CHK("wave match", 1'b1, hit)
    end
    `CHK("pin drive", 2'b11, pin_oe)
  endtask : check_waves
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    alt_out <= 2'($random(seed)); alt_oe <= 2'($random(seed));
    for (int i = 0; i < 4; i++) begin
      axi_rd(4'(i * 4));
      `CHK("reset reg", (i == 3) ? 8'h30 : 8'h00, rd[7:0])
    end
    `CHK("alt out", alt_out, pin_out)
    `CHK("alt oe", alt_oe, pin_oe)
    axi_rd(4'h2);
    `CHK("unmapped resp", dspwm_pkg::RESP_SLVERR, r)
    axi_wr(4'h2, 32'h0000_00FF);
    `CHK("bad write resp", dspwm_pkg::RESP_SLVERR, r)
    // software order: direction and data bits, then select, then duty
    axi_wr(dspwm_pkg::PORT_ADDR, 32'h0000_0003);
    `CHK("write resp", dspwm_pkg::RESP_OKAY, r)
    for (int m = 0; m < 2; m++) begin
      axi_wr(dspwm_pkg::CTRL_ADDR, m ? 32'h0000_00E0 : 32'h0000_0060);
      for (int k = 0; k < 6; k++) begin
        duty[0] = corner[k];
        duty[1] = 8'($random(seed));
        axi_wr(dspwm_pkg::DUTY0_ADDR, {24'h0, duty[0]});
        axi_wr(dspwm_pkg::DUTY1_ADDR, {24'h0, duty[1]});
        axi_rd(dspwm_pkg::DUTY1_ADDR);
        `CHK("duty back", duty[1], rd[7:0])
        repeat (600) @(posedge aclk);
        check_waves(1'(m));
      end
    end
    // data bit low forces channel 1 low while channel 0 runs
    axi_wr(dspwm_pkg::PORT_ADDR, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    for (int i = 0; i < 256; i++) begin
      @(posedge aclk);
      `CHK("forced low", 1'b0, pin_out[1])
    end
    // clock enable low must freeze the running waveform on the pins
    ce <= 0;
    @(posedge aclk);
    smp[0] = pin_out;
    for (int i = 0; i < 300; i++) begin
      @(posedge aclk);
      `CHK("ce freeze", smp[0], pin_out)
    end
    ce <= 1;
    axi_wr(dspwm_pkg::PORT_ADDR, 32'h0000_0021);
    repeat (8) @(posedge aclk);
    `CHK("input oe", 1'b0, pin_oe[1])
    `CHK("pull high", 1'b1, pin_sync[1])
    ext_oe <= 2'b10;
    repeat (8) @(posedge aclk);
    `CHK("input low", 1'b0, pin_sync[1])
    stop_test();
  end
endmodule : dspwm_top_tb
